// file: src/tts_map.vh
`ifndef TTS_MAP_VH
`define TTS_MAP_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define TTS_IDX_ONESHOT 10'h342
`define TTS_IDX_TRGSEL 10'h343
`define TTS_IDX_STATUS 10'h344
`define TTS_ADDR_W 12

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TTS_RST_ONESHOT 8'h00
`define TTS_RST_TRGSEL 8'h00

// ------------------------------------------------------------
// One-shot and control register fields
// ------------------------------------------------------------
`define TTS_OS_CH3_GO 3
`define TTS_OS_CH4_GO 4
`define TTS_OS_ZIE 5
`define TTS_OS_CH0_SEL_LO 6
`define TTS_OS_CH0_SEL_HI 7

// ------------------------------------------------------------
// Trigger select register fields (low bit, high bit)
// ------------------------------------------------------------
`define TTS_TS_CH1_LO 0
`define TTS_TS_CH1_HI 1
`define TTS_TS_CH2_LO 2
`define TTS_TS_CH2_HI 3
`define TTS_TS_CH3_LO 4
`define TTS_TS_CH3_HI 5
`define TTS_TS_CH4_LO 6
`define TTS_TS_CH4_HI 7

// ------------------------------------------------------------
// Selector codes
// ------------------------------------------------------------
`define TTS_SEL_PIN 2'h0
`define TTS_SEL_B2 2'h1
`define TTS_SEL_PREV 2'h2
`define TTS_SEL_NEXT 2'h3

`endif

// file: src/tts_top.v
// Added by the designer: register access over Avalon-MM.

`include "tts_map.vh"
`default_nettype none

// ------------------------------------------------------------
// Event source selector for one channel
// ------------------------------------------------------------
module tts_trig_mux (
  input wire clk,
  input wire rst,
  input wire [1:0] sel,
  input wire pin,
  input wire b2_ovf,
  input wire prev_ovf,
  input wire next_ovf,
  output reg trig
);

  reg next_trig;

  // Pick the event source by code
  always @* begin
    case (sel)
      `TTS_SEL_PIN: next_trig = pin;
      `TTS_SEL_B2: next_trig = b2_ovf;
      `TTS_SEL_PREV: next_trig = prev_ovf;
      `TTS_SEL_NEXT: next_trig = next_ovf;
      default: next_trig = pin;
    endcase
  end

  // Registered event output
  always @(posedge clk) begin
    if (rst) begin
      trig <= 1'b0;
    end else begin
      trig <= next_trig;
    end
  end

endmodule

// ------------------------------------------------------------
// Timer trigger select block
// ------------------------------------------------------------
module tts_top (
  input wire clk,
  input wire rst,
  input wire [11:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  input wire chan0_event_pin,
  input wire chan1_event_pin,
  input wire chan2_event_pin,
  input wire chan3_event_pin,
  input wire chan4_event_pin,
  input wire chan0_ovf,
  input wire chan1_ovf,
  input wire chan2_ovf,
  input wire chan3_ovf,
  input wire chan4_ovf,
  input wire second_group_unit_two_ovf,
  input wire zphase_pin,
  output wire chan0_trig,
  output wire chan1_trig,
  output wire chan2_trig,
  output wire chan3_trig,
  output wire chan4_trig,
  output reg chan3_start,
  output reg chan4_start,
  output reg zphase_event
);

  reg ack;
  reg chan3_oneshot_go;
  reg chan4_oneshot_go;
  reg zphase_input_enable;
  reg chan0_trig_sel_low;
  reg chan0_trig_sel_high;
  reg [7:0] trgsel;
  reg [7:0] next_rd;
  wire [9:0] idx;
  wire hit_os;
  wire hit_ts;
  wire hit_st;
  wire wr_lane0;
  wire [7:0] os_val;
  wire [7:0] st_val;

  // ------------------------------------------------------------
  // Avalon-MM slave handshake
  // ------------------------------------------------------------

  // Word index from byte address
  assign idx = address[11:2];
  assign hit_os = (idx == `TTS_IDX_ONESHOT);
  assign hit_ts = (idx == `TTS_IDX_TRGSEL);
  assign hit_st = (idx == `TTS_IDX_STATUS);
  assign wr_lane0 = write & ack & byteenable[0];

  // One wait cycle, then release
  assign waitrequest = (read | write) & ~ack;

  // Acknowledge one cycle after a request is taken
  always @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  // ------------------------------------------------------------
  // Register read path
  // ------------------------------------------------------------

  // One-shot bits read as zero after start
  assign os_val = {chan0_trig_sel_high, chan0_trig_sel_low,
                   zphase_input_enable, chan4_oneshot_go,
                   chan3_oneshot_go, 3'h0};
  // Live trigger and Z-phase state
  assign st_val = {2'h0, zphase_event, chan4_trig, chan3_trig,
                   chan2_trig, chan1_trig, chan0_trig};

  // Unmapped words read as zero
  always @* begin
    next_rd = 8'h00;
    if (hit_os) begin
      next_rd = os_val;
    end else if (hit_ts) begin
      next_rd = trgsel;
    end else if (hit_st) begin
      next_rd = st_val;
    end
  end

  // Read data captured when a read is taken
  always @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack) begin
      readdata <= {24'h00_0000, next_rd};
    end
  end

  // ------------------------------------------------------------
  // Register write path
  // ------------------------------------------------------------

  // One-shot and control register
  always @(posedge clk) begin
    if (rst) begin
      chan3_oneshot_go <= 1'b0;
      chan4_oneshot_go <= 1'b0;
      zphase_input_enable <= 1'b0;
      chan0_trig_sel_low <= 1'b0;
      chan0_trig_sel_high <= 1'b0;
    end else begin
      // Start bits return to idle after one cycle
      chan3_oneshot_go <= 1'b0;
      chan4_oneshot_go <= 1'b0;
      if (wr_lane0 & hit_os) begin
        chan3_oneshot_go <= writedata[`TTS_OS_CH3_GO];
        chan4_oneshot_go <= writedata[`TTS_OS_CH4_GO];
        zphase_input_enable <= writedata[`TTS_OS_ZIE];
        chan0_trig_sel_low <= writedata[`TTS_OS_CH0_SEL_LO];
        chan0_trig_sel_high <= writedata[`TTS_OS_CH0_SEL_HI];
      end
    end
  end

  // Trigger select register
  always @(posedge clk) begin
    if (rst) begin
      trgsel <= `TTS_RST_TRGSEL;
    end else if (wr_lane0 & hit_ts) begin
      trgsel <= writedata[7:0];
    end
  end

  // ------------------------------------------------------------
  // One-shot start and Z-phase gating
  // ------------------------------------------------------------

  // Start pulse only on a written 1
  always @(posedge clk) begin
    if (rst) begin
      chan3_start <= 1'b0;
      chan4_start <= 1'b0;
      zphase_event <= 1'b0;
    end else begin
      chan3_start <= chan3_oneshot_go;
      chan4_start <= chan4_oneshot_go;
      zphase_event <= zphase_pin & zphase_input_enable;
    end
  end

  // ------------------------------------------------------------
  // Per-channel event source selectors
  // ------------------------------------------------------------

  // Channel 0: ch4 then ch1 overflow
  tts_trig_mux u_sel0 (
    .clk(clk),
    .rst(rst),
    .sel({chan0_trig_sel_high, chan0_trig_sel_low}),
    .pin(chan0_event_pin),
    .b2_ovf(second_group_unit_two_ovf),
    .prev_ovf(chan4_ovf),
    .next_ovf(chan1_ovf),
    .trig(chan0_trig)
  );

  // Channel 1: ch0 then ch2 overflow
  tts_trig_mux u_sel1 (
    .clk(clk),
    .rst(rst),
    .sel({trgsel[`TTS_TS_CH1_HI], trgsel[`TTS_TS_CH1_LO]}),
    .pin(chan1_event_pin),
    .b2_ovf(second_group_unit_two_ovf),
    .prev_ovf(chan0_ovf),
    .next_ovf(chan2_ovf),
    .trig(chan1_trig)
  );

  // Channel 2: ch1 then ch3 overflow
  tts_trig_mux u_sel2 (
    .clk(clk),
    .rst(rst),
    .sel({trgsel[`TTS_TS_CH2_HI], trgsel[`TTS_TS_CH2_LO]}),
    .pin(chan2_event_pin),
    .b2_ovf(second_group_unit_two_ovf),
    .prev_ovf(chan1_ovf),
    .next_ovf(chan3_ovf),
    .trig(chan2_trig)
  );

  // Channel 3: ch2 then ch4 overflow
  tts_trig_mux u_sel3 (
    .clk(clk),
    .rst(rst),
    .sel({trgsel[`TTS_TS_CH3_HI], trgsel[`TTS_TS_CH3_LO]}),
    .pin(chan3_event_pin),
    .b2_ovf(second_group_unit_two_ovf),
    .prev_ovf(chan2_ovf),
    .next_ovf(chan4_ovf),
    .trig(chan3_trig)
  );

  // Channel 4: ch3 then ch0 overflow
  tts_trig_mux u_sel4 (
    .clk(clk),
    .rst(rst),
    .sel({trgsel[`TTS_TS_CH4_HI], trgsel[`TTS_TS_CH4_LO]}),
    .pin(chan4_event_pin),
    .b2_ovf(second_group_unit_two_ovf),
    .prev_ovf(chan3_ovf),
    .next_ovf(chan0_ovf),
    .trig(chan4_trig)
  );

endmodule

`default_nettype wire

// file: tb/test_timer_trigger_select.sv
`default_nettype none
module test_timer_trigger_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, read = 0, write = 0, b2 = 0, zp = 0;
  logic [11:0] address = 12'h000;
  logic [3:0] be = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, c3s, c4s, ze;
  logic [4:0] pin = 5'h00, ovf = 5'h00;
  wire logic [4:0] trig;
  logic [7:0] os_v = 8'h00, ts_v = 8'h00, d;
  int err_total = 0, n_checks = 0;

  tts_top u_dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(be), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .chan0_event_pin(pin[0]), .chan1_event_pin(pin[1]), .chan2_event_pin(pin[2]),
    .chan3_event_pin(pin[3]), .chan4_event_pin(pin[4]), .chan0_ovf(ovf[0]), .chan1_ovf(ovf[1]),
    .chan2_ovf(ovf[2]), .chan3_ovf(ovf[3]), .chan4_ovf(ovf[4]), .second_group_unit_two_ovf(b2),
    .zphase_pin(zp), .chan0_trig(trig[0]), .chan1_trig(trig[1]), .chan2_trig(trig[2]),
    .chan3_trig(trig[3]), .chan4_trig(trig[4]), .chan3_start(c3s), .chan4_start(c4s),
    .zphase_event(ze));

  initial forever #5 clk = ~clk;

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  // Bus cycle held until waitrequest is sampled low at a rising edge
  task automatic bus(bit wr, logic [11:0] a, logic [7:0] v);
    int n = 0;
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, v};
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      err_total++;
      summarize();
    end else begin
      q = readdata;
      read <= 0;
      write <= 0;
    end
  endtask

  task automatic rdchk(logic [11:0] a, logic [31:0] e, string m);
    bus(0, a, 8'h00);
    chk(q, e, m);
  endtask

  function automatic logic exp_trig(int c);
    logic [1:0] s = c == 0 ? os_v[7:6] : ts_v[2*c-2 +: 2];
    return s == 0 ? pin[c] : s == 1 ? b2 : s == 2 ? ovf[(c+4)%5] : ovf[(c+1)%5];
  endfunction

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    void'($urandom(31465));
    repeat (16) @(posedge clk);
    rst <= 0;
    rdchk(12'hD08, 0, "os reset");
    rdchk(12'hD0C, 0, "ts reset");
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      bus(1, 12'hD0C, d);
      rdchk(12'hD0C, {24'h0, d}, "ts rw");
      bus(1, 12'hD08, d & 8'hE7);
      rdchk(12'hD08, {24'h0, d & 8'hE0}, "os rw");
    end
    be <= 4'hE;
    bus(1, 12'hD0C, 8'h5A);
    be <= 4'hF;
    bus(1, 12'h100, 8'hFF);
    rdchk(12'hD0C, {24'h0, d}, "masked write");
    rdchk(12'h100, 0, "unmapped");
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      ts_v = k < 4 ? {4{k[1:0]}} : 8'($urandom);
      os_v = k < 4 ? {k[1:0], k[0], 5'h00} : 8'($urandom) & 8'hE0;
      bus(1, 12'hD0C, ts_v);
      bus(1, 12'hD08, os_v);
      repeat (12) begin
        @(posedge clk);
        pin <= 5'($urandom);
        ovf <= 5'($urandom);
        b2 <= 1'($urandom);
        zp <= 1'($urandom);
        @(posedge clk);
        #1;
        for (int c = 0; c < 5; c++)
          chk(trig[c], exp_trig(c), "trigger source");
        chk(ze, zp & os_v[5], "zphase gate");
      end
      // Status word with inputs held steady
      rdchk(12'hD10, {26'h0, zp & os_v[5], exp_trig(4), exp_trig(3), exp_trig(2),
        exp_trig(1), exp_trig(0)}, "status");
    end
    $display("test sources done");
    for (int ch = 3; ch < 5; ch++) begin
      bus(1, 12'hD08, os_v | (ch == 3 ? 8'h08 : 8'h10));
      for (int t = 0; t < 6; t++) begin
        @(posedge clk);
        #1;
        chk(c3s, t == 0 && ch == 3, "ch3 start");
        chk(c4s, t == 0 && ch == 4, "ch4 start");
      end
    end
    rdchk(12'hD08, {24'h0, os_v}, "go clear");
    $display("test oneshot done");
    summarize();
  end
endmodule
`default_nettype wire

// file: tb/tts_checker.sv
`default_nettype none
module tts_checker (
  input wire logic clk, rst, read, write, waitrequest,
  input wire logic [11:0] address,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic chan0_event_pin, chan1_event_pin, chan2_event_pin, chan3_event_pin,
  input wire logic chan4_event_pin, chan0_ovf, chan1_ovf, chan2_ovf, chan3_ovf, chan4_ovf,
  input wire logic second_group_unit_two_ovf, zphase_pin, zphase_event, chan3_start,
  input wire logic chan0_trig, chan1_trig, chan2_trig, chan3_trig, chan4_trig, chan4_start
);
  logic [7:0] os, ts;
  logic [4:0] exp;
  wire logic done = write && !waitrequest && byteenable[0];
  wire logic go3 = done && address == 12'hD08 && writedata[3];
  wire logic go4 = done && address == 12'hD08 && writedata[4];
  wire logic req = read || write;
  wire logic zq = zphase_pin & os[5];
  wire logic [9:0] sl = {ts, os[7:6]};
  wire logic [4:0] pin = {chan4_event_pin, chan3_event_pin, chan2_event_pin, chan1_event_pin,
    chan0_event_pin};
  wire logic [4:0] ovf = {chan4_ovf, chan3_ovf, chan2_ovf, chan1_ovf, chan0_ovf};

  function automatic logic pick(logic [1:0] s, logic p, logic b, logic a, logic n);
    return s == 2'h0 ? p : s == 2'h1 ? b : s == 2'h2 ? a : n;
  endfunction

  // Mirror of selects and expected sources
  always @(posedge clk) begin
    if (rst) begin
      os <= 8'h00;
      ts <= 8'h00;
      exp <= 5'h00;
    end else begin
      if (done && address == 12'hD08)
        os <= writedata[7:0];
      if (done && address == 12'hD0C)
        ts <= writedata[7:0];
      for (int i = 0; i < 5; i++)
        exp[i] <= pick(sl[2*i +: 2], pin[i], second_group_unit_two_ovf, ovf[(i+4)%5],
          ovf[(i+1)%5]);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_trig_ch0: assert property (chan0_trig == exp[0]) else $error("ch0 source");
  a_trig_ch1: assert property (chan1_trig == exp[1]) else $error("ch1 source");
  a_trig_ch2: assert property (chan2_trig == exp[2]) else $error("ch2 source");
  a_trig_ch3: assert property (chan3_trig == exp[3]) else $error("ch3 source");
  a_trig_ch4: assert property (chan4_trig == exp[4]) else $error("ch4 source");
  a_zphase_gate: assert property (zphase_event == $past(zq)) else $error("zphase gate");
  a_start3_pulse: assert property (go3 |-> ##2 chan3_start ##1 !chan3_start)
    else $error("ch3 start pulse");
  a_start3_cause: assert property (chan3_start |-> $past(go3, 2))
    else $error("ch3 start uncaused");
  a_start4_pulse: assert property (go4 |-> ##2 chan4_start ##1 !chan4_start)
    else $error("ch4 start pulse");
  a_start4_cause: assert property (chan4_start |-> $past(go4, 2))
    else $error("ch4 start uncaused");
  a_bus_wait: assert property ($rose(req) |-> waitrequest ##1 !waitrequest)
    else $error("wait cycle");
endmodule

bind tts_top tts_checker u_chk (.*);
`default_nettype wire
